// ==== verilog/umisr_pkg.sv ====
// Package with register map, field layout and reset values of the mode, interrupt and status block
//Contract
// - Optical enable inverts transmit data before modulator
// - Receive invert flips comparator output to receiver
// - Modulator invert flips modulated output
// - Filter takes 2-of-3 majority at 16x
// - Parity field: even, odd, space, mark, none
// - Modulation clock is PLL over 8*(div+8)
// - Duty field lowers duty 6.25% per step
// - Threshold code forwarded to comparator
// - Enable-set write sets mask bits written one
// - Enable-clear write clears mask bits written one
// - Mask view reads current enable bits
// - Shared bit layout for mask and status
// - Receive ready while unread character held
// - Transmit ready when holding register free, enabled
// - Overrun sticky until status clear
// - Framing error sticky until status clear
// - Parity error sticky until status clear
// - Transmitter idle only when fully empty, enabled
// - DMA end flags mirror channel signals
// - Status clear command clears error flags
// - Echo mode retransmits receive pin bits, or comparator bits with optics
// - Local loopback feeds transmitter to receiver
// - Remote loopback ties pin to pin
package umisr_pkg;
	localparam logic [7:0]  UMISR_OFS_CMD    = 8'h00;
	localparam logic [7:0]  UMISR_OFS_MODE   = 8'h04;
	localparam logic [7:0]  UMISR_OFS_IEN    = 8'h08;
	localparam logic [7:0]  UMISR_OFS_IDIS   = 8'h0C;
	localparam logic [7:0]  UMISR_OFS_IMASK  = 8'h10;
	localparam logic [7:0]  UMISR_OFS_STAT   = 8'h14;
	localparam logic [31:0] UMISR_MODE_RST   = 32'h0013_0000;
	localparam logic [31:0] UMISR_MODE_WMASK = 32'h771F_CE17;
	localparam logic [31:0] UMISR_IRQ_WMASK  = 32'h0000_1AFB;
	localparam int UMISR_B_CMD_CLR  = 8;
	localparam int UMISR_B_OPTICAL_ENABLE   = 0;
	localparam int UMISR_B_RXINV    = 1;
	localparam int UMISR_B_MDINV    = 2;
	localparam int UMISR_B_FILTER   = 4;
	localparam int UMISR_B_PAR      = 9;
	localparam int UMISR_B_CHANNEL_TEST_MODE   = 14;
	localparam int UMISR_B_CLKDIV   = 16;
	localparam int UMISR_B_DUTY     = 24;
	localparam int UMISR_B_CMPTH    = 28;
	localparam int UMISR_S_RX_CHAR_READY    = 0;
	localparam int UMISR_S_TX_HOLDING_FREE    = 1;
	localparam int UMISR_S_DMA_RX_END    = 3;
	localparam int UMISR_S_DMA_TX_END    = 4;
	localparam int UMISR_S_OVERRUN_FLAG     = 5;
	localparam int UMISR_S_FRAME    = 6;
	localparam int UMISR_S_PARITY_ERROR_FLAG     = 7;
	localparam int UMISR_S_TX_IDLE_FLAG  = 9;
	localparam int UMISR_S_DMA_TX_BUFFER_EMPTY   = 11;
	localparam int UMISR_S_DMA_RX_BUFFER_FULL   = 12;
	localparam logic [5:0] UMISR_DIV_BASE = 6'h08;
	localparam logic [3:0] UMISR_DUTY_FULL = 4'h8;
	typedef enum logic [2:0] {
		UMISR_PAR_EVEN,
		UMISR_PAR_ODD,
		UMISR_PAR_SPACE,
		UMISR_PAR_MARK,
		UMISR_PAR_NONE
	} umisr_par_type;
	typedef enum logic [1:0] {
		UMISR_CH_NORMAL,
		UMISR_CH_ECHO,
		UMISR_CH_LOCAL,
		UMISR_CH_REMOTE
	} umisr_channel_test_mode_type;
endpackage : umisr_pkg

// ==== verilog/umisr_top.sv ====
// Mode, interrupt mask and status logic of a simple asynchronous serial port
module umisr_top
	import umisr_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        optical_pll_clock,
	input  wire logic        baud16_tick,
	input  wire logic        serial_in_pin,
	input  wire logic        comparator_out,
	output logic             serial_out_pin,
	input  wire logic        tx_serial_data,
	output logic             rx_serial_data,
	input  wire logic        rx_enabled,
	input  wire logic        tx_enabled,
	input  wire logic        rx_char_loaded,
	input  wire logic        rx_holding_read,
	input  wire logic        tx_holding_written,
	input  wire logic        tx_holding_moved,
	input  wire logic        tx_shifting,
	input  wire logic        overrun_event,
	input  wire logic        framing_event,
	input  wire logic        parity_event,
	input  wire logic        dma_rx_end,
	input  wire logic        dma_tx_end,
	input  wire logic        dma_tx_buffer_empty,
	input  wire logic        dma_rx_buffer_full,
	output logic      [2:0]  parity_type,
	output logic      [1:0]  channel_test_mode,
	output logic      [2:0]  comparator_threshold_code,
	output logic             optical_enable,
	output logic             irq
);
	import umisr_pkg::*;

	logic [31:0] mode_q;
	logic [31:0] mask_q;
	logic [31:0] stat_w;
	logic        rx_full_q;
	logic        tx_busy_q;
	logic        overrun_flag_q;
	logic        frame_q;
	logic        parity_error_flag_q;
	logic [1:0]  rin_s_q;
	logic [1:0]  cmp_s_q;
	logic [1:0]  pll_s_q;
	logic [2:0]  filt_q;
	logic        pll_d_q;
	logic [5:0]  pre_q;
	logic [2:0]  ph_q;
	logic        mod_clk;
	logic        rx_line;
	logic        rx_filt;
	logic        mod_out;
	logic        tx_drv;
	logic        clr_cmd;
	logic        wr_mode;
	logic        wr_ien;
	logic        wr_idis;
	logic        pll_rise;
	logic [5:0]  div_val;
	logic [3:0]  high_ph;
	logic [2:0]  ph_cnt;
	logic [1:0]  chm;

	assign wr_mode = reg_wr && reg_addr == UMISR_OFS_MODE;
	assign wr_ien  = reg_wr && reg_addr == UMISR_OFS_IEN;
	assign wr_idis = reg_wr && reg_addr == UMISR_OFS_IDIS;
	assign clr_cmd = reg_wr && reg_addr == UMISR_OFS_CMD && reg_wdata[UMISR_B_CMD_CLR];
	assign chm     = mode_q[UMISR_B_CHANNEL_TEST_MODE +: 2];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_q <= UMISR_MODE_RST;
		end else if (wr_mode) begin
			mode_q <= reg_wdata & UMISR_MODE_WMASK;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mask_q <= 32'h0000_0000;
		end else if (wr_ien) begin
			mask_q <= mask_q | (reg_wdata & UMISR_IRQ_WMASK);
		end else if (wr_idis) begin
			mask_q <= mask_q & ~reg_wdata;
		end
	end

	// Character flags; a new character wins over a read in the same cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_full_q <= 1'b0;
		end else if (!rx_enabled) begin
			rx_full_q <= 1'b0;
		end else if (rx_char_loaded) begin
			rx_full_q <= 1'b1;
		end else if (rx_holding_read) begin
			rx_full_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_busy_q <= 1'b0;
		end else if (tx_holding_written) begin
			tx_busy_q <= 1'b1;
		end else if (tx_holding_moved) begin
			tx_busy_q <= 1'b0;
		end
	end

	// Error flags: set beats the clear command
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			overrun_flag_q  <= 1'b0;
			frame_q <= 1'b0;
			parity_error_flag_q  <= 1'b0;
		end else begin
			overrun_flag_q  <= overrun_event | (overrun_flag_q & ~clr_cmd);
			frame_q <= framing_event | (frame_q & ~clr_cmd);
			parity_error_flag_q  <= parity_event | (parity_error_flag_q & ~clr_cmd);
		end
	end

	always_comb begin
		stat_w = 32'h0000_0000;
		stat_w[UMISR_S_RX_CHAR_READY]   = rx_full_q;
		stat_w[UMISR_S_TX_HOLDING_FREE]   = tx_enabled && !tx_busy_q;
		stat_w[UMISR_S_DMA_RX_END]   = dma_rx_end;
		stat_w[UMISR_S_DMA_TX_END]   = dma_tx_end;
		stat_w[UMISR_S_OVERRUN_FLAG]    = overrun_flag_q;
		stat_w[UMISR_S_FRAME]   = frame_q;
		stat_w[UMISR_S_PARITY_ERROR_FLAG]    = parity_error_flag_q;
		stat_w[UMISR_S_TX_IDLE_FLAG] = tx_enabled && !tx_busy_q && !tx_shifting;
		stat_w[UMISR_S_DMA_TX_BUFFER_EMPTY]  = dma_tx_buffer_empty;
		stat_w[UMISR_S_DMA_RX_BUFFER_FULL]  = dma_rx_buffer_full;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				UMISR_OFS_MODE:  reg_rdata <= mode_q;
				UMISR_OFS_IMASK: reg_rdata <= mask_q;
				UMISR_OFS_STAT:  reg_rdata <= stat_w;
				default:         reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_w & mask_q);
		end
	end

	// Pin synchronisers; first stages feed only second stages
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rin_s_q <= 2'b11;
			cmp_s_q <= 2'b11;
			pll_s_q <= 2'b00;
		end else begin
			rin_s_q <= {rin_s_q[0], serial_in_pin};
			cmp_s_q <= {cmp_s_q[0], comparator_out};
			pll_s_q <= {pll_s_q[0], optical_pll_clock};
		end
	end

	// Optical path selects comparator, optionally inverted
	assign rx_line = mode_q[UMISR_B_OPTICAL_ENABLE] ? (cmp_s_q[1] ^ mode_q[UMISR_B_RXINV]) : rin_s_q[1];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			filt_q <= 3'b111;
		end else if (baud16_tick) begin
			filt_q <= {filt_q[1:0], rx_line};
		end
	end

	assign rx_filt = mode_q[UMISR_B_FILTER] ?
		((filt_q[0] & filt_q[1]) | (filt_q[1] & filt_q[2]) | (filt_q[0] & filt_q[2])) : rx_line;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_serial_data <= 1'b1;
		end else begin
			unique case (chm)
				UMISR_CH_LOCAL:  rx_serial_data <= tx_serial_data;
				UMISR_CH_REMOTE: rx_serial_data <= 1'b1;
				default:         rx_serial_data <= rx_filt;
			endcase
		end
	end

	// Modulation clock: PLL edges divided by (div+8), eight phases per period
	// The PLL clock is sampled, so it must be well below half of ref_clk
	assign pll_rise = pll_s_q[1] & ~pll_d_q;
	assign div_val  = UMISR_DIV_BASE + {1'b0, mode_q[UMISR_B_CLKDIV +: 5]};
	assign high_ph  = UMISR_DUTY_FULL - {1'b0, mode_q[UMISR_B_DUTY +: 3]};
	assign ph_cnt   = ph_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pll_d_q <= 1'b0;
			pre_q   <= 6'h00;
			ph_q    <= 3'h0;
		end else begin
			pll_d_q <= pll_s_q[1];
			if (pll_rise) begin
				if (pre_q >= div_val - 6'h01) begin
					pre_q <= 6'h00;
					ph_q  <= ph_q + 3'h1;
				end else begin
					pre_q <= pre_q + 6'h01;
				end
			end
		end
	end

	// High for (8-duty) half phases; an odd count ends mid phase, rounded down for odd dividers
	assign mod_clk = (ph_cnt < high_ph[3:1]) ||
		(ph_cnt == high_ph[3:1] && high_ph[0] && pre_q < (div_val >> 1));

	// Data high modulates; data low is stuck at one, or at zero with modulator invert
	assign mod_out = ((tx_serial_data ^ mode_q[UMISR_B_OPTICAL_ENABLE]) ? 1'b1 : ~mod_clk) ^ mode_q[UMISR_B_MDINV];

	always_comb begin
		unique case (chm)
			UMISR_CH_ECHO:   tx_drv = rx_filt;
			UMISR_CH_LOCAL:  tx_drv = 1'b1;
			UMISR_CH_REMOTE: tx_drv = rin_s_q[1];
			default:         tx_drv = mode_q[UMISR_B_OPTICAL_ENABLE] ? mod_out : tx_serial_data;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			serial_out_pin            <= 1'b1;
			parity_type               <= UMISR_MODE_RST[UMISR_B_PAR +: 3];
			channel_test_mode         <= UMISR_MODE_RST[UMISR_B_CHANNEL_TEST_MODE +: 2];
			comparator_threshold_code <= UMISR_MODE_RST[UMISR_B_CMPTH +: 3];
			optical_enable            <= 1'b0;
		end else begin
			serial_out_pin            <= tx_drv;
			parity_type               <= mode_q[UMISR_B_PAR +: 3];
			channel_test_mode         <= chm;
			comparator_threshold_code <= mode_q[UMISR_B_CMPTH +: 3];
			optical_enable            <= mode_q[UMISR_B_OPTICAL_ENABLE];
		end
	end

	a_mask_set: assert property (@(posedge ref_clk) disable iff (rst)
		wr_ien |=> ((mask_q & $past(reg_wdata) & UMISR_IRQ_WMASK) == ($past(reg_wdata) & UMISR_IRQ_WMASK)))
		else $error("enable write did not set mask");
	a_mask_clear: assert property (@(posedge ref_clk) disable iff (rst)
		wr_idis |=> ((mask_q & $past(reg_wdata)) == 32'h0000_0000))
		else $error("disable write did not clear mask");
	a_mask_read: assert property (@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == UMISR_OFS_IMASK |=> reg_rdata == $past(mask_q))
		else $error("mask read wrong");
	a_overrun_flag_sticky: assert property (@(posedge ref_clk) disable iff (rst)
		overrun_flag_q && !clr_cmd |=> overrun_flag_q)
		else $error("overrun flag lost");
	a_err_clear: assert property (@(posedge ref_clk) disable iff (rst)
		clr_cmd && !parity_event && !framing_event |=> !parity_error_flag_q && !frame_q)
		else $error("clear command ignored");
	a_irq_out: assert property (@(posedge ref_clk) disable iff (rst)
		|(stat_w & mask_q) |=> irq)
		else $error("interrupt missing");
	a_rx_ready: assert property (@(posedge ref_clk) disable iff (rst)
		rx_enabled && rx_char_loaded |=> stat_w[UMISR_S_RX_CHAR_READY])
		else $error("receive ready missing");
	a_tx_empty: assert property (@(posedge ref_clk) disable iff (rst)
		!tx_enabled |-> !stat_w[UMISR_S_TX_IDLE_FLAG])
		else $error("idle flag while disabled");

	// Mode fields reach their outputs two cycles after the write; divider and duty fields are checked in mode_q one cycle after
	a_parity_field: assert property (@(posedge ref_clk) disable iff (rst)
		wr_mode |=> ##1 (parity_type == $past(reg_wdata[UMISR_B_PAR +: 3], 2)))
		else $error("parity field not forwarded");
	a_cmpth_field: assert property (@(posedge ref_clk) disable iff (rst)
		wr_mode |=> ##1 (comparator_threshold_code == $past(reg_wdata[UMISR_B_CMPTH +: 3], 2)))
		else $error("threshold code not forwarded");
	a_channel_test_mode_field: assert property (@(posedge ref_clk) disable iff (rst)
		wr_mode |=> ##1 (channel_test_mode == $past(reg_wdata[UMISR_B_CHANNEL_TEST_MODE +: 2], 2)))
		else $error("channel mode not forwarded");
	a_opt_flag: assert property (@(posedge ref_clk) disable iff (rst)
		wr_mode |=> ##1 (optical_enable == $past(reg_wdata[UMISR_B_OPTICAL_ENABLE], 2)))
		else $error("optical enable not forwarded");
	a_divider_field: assert property (@(posedge ref_clk) disable iff (rst)
		wr_mode |=> (mode_q[UMISR_B_CLKDIV +: 5] == $past(reg_wdata[UMISR_B_CLKDIV +: 5])))
		else $error("divider field not stored");
	a_duty_field: assert property (@(posedge ref_clk) disable iff (rst)
		wr_mode |=> (mode_q[UMISR_B_DUTY +: 3] == $past(reg_wdata[UMISR_B_DUTY +: 3])))
		else $error("duty field not stored");

	// Optical path in normal mode, and plain receive pin path without optics
	logic        opt_norm;
	assign opt_norm = mode_q[UMISR_B_OPTICAL_ENABLE] && chm == UMISR_CH_NORMAL;
	a_opt_stuck: assert property (@(posedge ref_clk) disable iff (rst)
		opt_norm && !mode_q[UMISR_B_MDINV] && !tx_serial_data |=> serial_out_pin)
		else $error("inverted idle data not stuck high");
	a_mod_invert: assert property (@(posedge ref_clk) disable iff (rst)
		opt_norm && mode_q[UMISR_B_MDINV] && !tx_serial_data |=> !serial_out_pin)
		else $error("modulator output not inverted");
	a_mod_follow: assert property (@(posedge ref_clk) disable iff (rst)
		opt_norm && !mode_q[UMISR_B_MDINV] && tx_serial_data |=> (serial_out_pin == !$past(mod_clk)))
		else $error("modulated output wrong");
	a_rx_invert: assert property (@(posedge ref_clk) disable iff (rst)
		opt_norm && !mode_q[UMISR_B_FILTER] |=> (rx_serial_data == ($past(cmp_s_q[1]) ^ $past(mode_q[UMISR_B_RXINV]))))
		else $error("comparator polarity wrong");
	a_rx_plain: assert property (@(posedge ref_clk) disable iff (rst)
		!mode_q[UMISR_B_OPTICAL_ENABLE] && !mode_q[UMISR_B_FILTER] && !chm[1] |=> (rx_serial_data == $past(rin_s_q[1])))
		else $error("receive pin not passed");

	// Receive filter
	a_filter_early: assert property (@(posedge ref_clk) disable iff (rst)
		mode_q[UMISR_B_FILTER] && (filt_q[0] == filt_q[1]) |-> (rx_filt == filt_q[0]))
		else $error("filter majority wrong");
	a_filter_late: assert property (@(posedge ref_clk) disable iff (rst)
		mode_q[UMISR_B_FILTER] && (filt_q[1] == filt_q[2]) |-> (rx_filt == filt_q[1]))
		else $error("filter majority wrong");
	a_filter_hold: assert property (@(posedge ref_clk) disable iff (rst)
		!baud16_tick |=> $stable(filt_q))
		else $error("filter sampled off tick");

	// Modulation clock divider and duty
	a_phase_step: assert property (@(posedge ref_clk) disable iff (rst)
		pll_rise && pre_q == div_val - 6'h01 |=> (ph_q == $past(ph_q) + 3'h1) && (pre_q == 6'h00))
		else $error("phase did not advance");
	a_prescale_step: assert property (@(posedge ref_clk) disable iff (rst)
		pll_rise && pre_q < div_val - 6'h01 |=> (pre_q == $past(pre_q) + 6'h01) && $stable(ph_q))
		else $error("prescaler did not count");
	a_prescale_idle: assert property (@(posedge ref_clk) disable iff (rst)
		!pll_rise |=> $stable(pre_q) && $stable(ph_q))
		else $error("divider moved without edge");
	a_duty_low: assert property (@(posedge ref_clk) disable iff (rst)
		ph_q[2] |-> !mod_clk)
		else $error("modulation clock high past half");
	a_duty_half: assert property (@(posedge ref_clk) disable iff (rst)
		mode_q[UMISR_B_DUTY +: 3] == 3'h0 && !ph_q[2] |-> mod_clk)
		else $error("half duty not high");

	// Channel test modes
	a_echo_path: assert property (@(posedge ref_clk) disable iff (rst)
		chm == UMISR_CH_ECHO |=> (serial_out_pin == $past(rx_filt)))
		else $error("echo not retransmitted");
	a_local_loop: assert property (@(posedge ref_clk) disable iff (rst)
		chm == UMISR_CH_LOCAL |=> serial_out_pin && (rx_serial_data == $past(tx_serial_data)))
		else $error("local loopback wrong");
	a_remote_loop: assert property (@(posedge ref_clk) disable iff (rst)
		chm == UMISR_CH_REMOTE |=> rx_serial_data && (serial_out_pin == $past(rin_s_q[1])))
		else $error("remote loopback wrong");

	// Mask, flags and read port
	a_mask_keep: assert property (@(posedge ref_clk) disable iff (rst)
		wr_ien |=> ((mask_q & ~$past(reg_wdata)) == ($past(mask_q) & ~$past(reg_wdata))))
		else $error("enable write touched zero bits");
	a_mask_spare: assert property (@(posedge ref_clk) disable iff (rst)
		wr_idis |=> ((mask_q & ~$past(reg_wdata)) == ($past(mask_q) & ~$past(reg_wdata))))
		else $error("disable write touched zero bits");
	a_read_idle: assert property (@(posedge ref_clk) disable iff (rst)
		!reg_rd |=> (reg_rdata == 32'h0000_0000))
		else $error("read data outside read cycle");
	a_overrun_set: assert property (@(posedge ref_clk) disable iff (rst)
		overrun_event |=> overrun_flag_q)
		else $error("overrun not flagged");
	a_frame_sticky: assert property (@(posedge ref_clk) disable iff (rst)
		frame_q && !clr_cmd |=> frame_q)
		else $error("framing flag lost");
	a_parity_sticky: assert property (@(posedge ref_clk) disable iff (rst)
		parity_error_flag_q && !clr_cmd |=> parity_error_flag_q)
		else $error("parity flag lost");
	a_overrun_flag_clear: assert property (@(posedge ref_clk) disable iff (rst)
		clr_cmd && !overrun_event |=> !overrun_flag_q)
		else $error("overrun not cleared");
	a_rx_cleared: assert property (@(posedge ref_clk) disable iff (rst)
		rx_holding_read && !rx_char_loaded |=> !stat_w[UMISR_S_RX_CHAR_READY])
		else $error("receive ready after read");
	a_tx_pending: assert property (@(posedge ref_clk) disable iff (rst)
		tx_holding_written |=> !stat_w[UMISR_S_TX_HOLDING_FREE])
		else $error("transmit ready while pending");
	a_irq_quiet: assert property (@(posedge ref_clk) disable iff (rst)
		!(|(stat_w & mask_q)) |=> !irq)
		else $error("interrupt without source");
endmodule : umisr_top

// ==== dv/umisr_line_model.sv ====
// Remote serial device model driving the receive pin and comparator line
module umisr_line_model #(
	parameter logic [7:0] PATTERN = 8'hA5
) (
	input  wire logic send,
	input  wire logic ref_clk,
	output logic      serial_in_pin,
	output logic      comparator_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] cnt;
	initial begin
		cnt = 6'h00;
		serial_in_pin = 1'b1;
		comparator_out = 1'b1;
	end
	// Each bit stands eight cycles so the receive synchroniser never misses one; idle is the stop level
	always @(posedge ref_clk) begin
		if (!send) begin
			cnt <= 6'h00;
			serial_in_pin <= 1'b1;
			comparator_out <= 1'b1;
		end else begin
			cnt <= cnt + 6'h01;
			serial_in_pin <= PATTERN[cnt[5:3]];
			comparator_out <= PATTERN[cnt[5:3]];
		end
	end
endmodule : umisr_line_model

// ==== dv/test_uart_mode_irq_status_regs.sv ====
// Self-checking bench for the mode, interrupt mask and status block
module test_uart_mode_irq_status_regs import umisr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] PAT = 8'hA5;
	logic        ref_clk, rst, reg_wr, reg_rd, optical_pll_clock, baud16_tick, send, tx_serial_data;
	logic        rx_enabled, tx_enabled, tx_shifting, serial_in_pin, comparator_out, serial_out_pin;
	logic        rx_serial_data, irq, optical_enable;
	logic [6:0]  ev_q;
	logic [3:0]  dma_q;
	logic [7:0]  reg_addr, tick;
	logic [31:0] reg_wdata, reg_rdata, rdata_q;
	logic [2:0]  parity_type, comparator_threshold_code;
	logic [1:0]  channel_test_mode;
	int          mismatches, num_checks, cyc;
	umisr_top u_dut (
		.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .optical_pll_clock, .baud16_tick,
		.serial_in_pin, .comparator_out, .serial_out_pin, .tx_serial_data, .rx_serial_data, .rx_enabled,
		.tx_enabled, .rx_char_loaded(ev_q[3]), .rx_holding_read(ev_q[2]), .tx_holding_written(ev_q[1]),
		.tx_holding_moved(ev_q[0]), .tx_shifting, .overrun_event(ev_q[6]), .framing_event(ev_q[5]),
		.parity_event(ev_q[4]), .dma_rx_end(dma_q[3]), .dma_tx_end(dma_q[2]), .dma_tx_buffer_empty(dma_q[1]),
		.dma_rx_buffer_full(dma_q[0]), .parity_type, .channel_test_mode, .comparator_threshold_code,
		.optical_enable, .irq
	);
	umisr_line_model #(.PATTERN(PAT)) u_line (.send, .ref_clk, .serial_in_pin, .comparator_out);
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// Slow sampled clock and filter strobe come from a free-running count
	always @(posedge ref_clk) begin
		tick <= tick + 8'h01;
		baud16_tick <= (tick[1:0] == 2'h0);
		optical_pll_clock <= tick[4];
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		rdata_q = reg_rdata;
	endtask : rd
	task automatic ev(input logic [6:0] m);
		@(posedge ref_clk);
		ev_q <= m;
		@(posedge ref_clk);
		ev_q <= 7'h00;
	endtask : ev
	task automatic sts(input logic [31:0] m, input logic [31:0] e);
		rd(UMISR_OFS_STAT);
		chk(rdata_q & m, e);
	endtask : sts
	task automatic t_mode;
		logic [31:0] v;
		rd(UMISR_OFS_MODE);
		chk(rdata_q, UMISR_MODE_RST);
		chk(parity_type, 32'(UMISR_MODE_RST[UMISR_B_PAR +: 3]));
		for (int i = 0; i < 5; i++) begin
			v = 32'h8000_0000 | (32'(i) << UMISR_B_PAR) | (32'(i) << UMISR_B_CMPTH) | (32'(i % 4) << UMISR_B_CHANNEL_TEST_MODE);
			v = v | 32'(i % 2);
			wr(UMISR_OFS_MODE, v);
			rd(UMISR_OFS_MODE);
			chk(rdata_q, v & UMISR_MODE_WMASK);
			chk(parity_type, 32'(i));
			chk(comparator_threshold_code, 32'(i));
			chk(channel_test_mode, 32'(i % 4));
			chk(optical_enable, 32'(i % 2));
		end
		wr(UMISR_OFS_MODE, UMISR_MODE_RST);
		$display("mode test done");
	endtask : t_mode
	task automatic t_mask;
		rd(UMISR_OFS_IMASK);
		chk(rdata_q, 32'h0000_0000);
		wr(UMISR_OFS_IEN, 32'hFFFF_FFFF);
		rd(UMISR_OFS_IMASK);
		chk(rdata_q, 32'h0000_1AFB);
		wr(UMISR_OFS_IDIS, 32'h0000_00F0);
		wr(UMISR_OFS_IEN, 32'h0000_0010);
		wr(UMISR_OFS_IMASK, 32'h0000_0000);
		rd(UMISR_OFS_IMASK);
		chk(rdata_q, 32'h0000_1A1B);
		rd(8'h40);
		chk(rdata_q, 32'h0000_0000);
		$display("mask test done");
	endtask : t_mask
	task automatic t_flags;
		wr(UMISR_OFS_IDIS, 32'hFFFF_FFFF);
		wr(UMISR_OFS_IEN, 32'h1 << UMISR_S_OVERRUN_FLAG);
		ev(7'h70);
		sts(32'h0000_00E0, 32'h0000_00E0);
		chk(irq, 32'h1);
		wr(UMISR_OFS_CMD, 32'h1 << UMISR_B_CMD_CLR);
		sts(32'h0000_00E0, 32'h0000_0000);
		chk(irq, 32'h0);
		ev(7'h08);
		sts(32'h1, 32'h1);
		ev(7'h04);
		sts(32'h1, 32'h0);
		ev(7'h02);
		sts(32'h202, 32'h0);
		@(posedge ref_clk) tx_shifting <= 1'b1;
		ev(7'h01);
		sts(32'h202, 32'h2);
		@(posedge ref_clk) tx_shifting <= 1'b0;
		sts(32'h202, 32'h202);
		@(posedge ref_clk) tx_enabled <= 1'b0;
		sts(32'h202, 32'h0);
		for (int i = 5; i < 11; i += 5) begin
			@(posedge ref_clk) dma_q <= 4'(i);
			sts(32'h1818, (32'(i / 8) << 3) | (32'(i / 4 % 2) << 4) | (32'(i / 2 % 2) << 11) | (32'(i % 2) << 12));
		end
		$display("flag test done");
	endtask : t_flags
	task automatic t_loop;
		for (int m = 1; m < 4; m += 2) begin
			wr(UMISR_OFS_MODE, UMISR_MODE_RST | (32'(m) << UMISR_B_CHANNEL_TEST_MODE));
			@(posedge ref_clk) send <= 1'b1;
			repeat (7) @(posedge ref_clk);
			for (int k = 0; k < 8; k++) begin
				#1 chk(serial_out_pin, 32'(PAT[k]));
				repeat (8) @(posedge ref_clk);
			end
			send <= 1'b0;
		end
		wr(UMISR_OFS_MODE, UMISR_MODE_RST | (32'h2 << UMISR_B_CHANNEL_TEST_MODE));
		send <= 1'b1;
		tx_serial_data <= 1'b0;
		repeat (6) @(posedge ref_clk);
		#1 chk({rx_serial_data, serial_out_pin}, 32'h1);
		send <= 1'b0;
		$display("loop test done");
	endtask : t_loop
	// Pll input is tick[4], 32 cycles; divider 0 and duty 3 give 640 low cycles of 2048
	task automatic t_optical;
		int lows;
		lows = 0;
		wr(UMISR_OFS_MODE, 32'h0300_0007);
		repeat (3) @(posedge ref_clk);
		#1 chk({rx_serial_data, serial_out_pin}, 32'h0);
		wr(UMISR_OFS_MODE, 32'h0300_0001);
		tx_serial_data <= 1'b1;
		repeat (2048) @(posedge ref_clk);
		repeat (2048) begin
			@(posedge ref_clk);
			#1 lows += int'(!serial_out_pin);
		end
		chk(32'(lows), 32'(32 * 8 * (0 + 8) * (8 - 3) / 16));
		chk(rx_serial_data, 32'h1);
		wr(UMISR_OFS_MODE, UMISR_MODE_RST);
		$display("optical test done");
	endtask : t_optical
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict
	initial begin
		{rst, reg_wr, reg_rd, send, tx_shifting, ev_q, dma_q, reg_addr, reg_wdata, tick} = '0;
		{tx_serial_data, rx_enabled, tx_enabled, optical_pll_clock, baud16_tick} = 5'h1C;
		{mismatches, num_checks, cyc} = '0;
		rst = 1'b1;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		t_mode();
		t_mask();
		t_flags();
		t_loop();
		t_optical();
		print_verdict();
	end
endmodule : test_uart_mode_irq_status_regs
